// ---- inc/lcdrl_pkg.sv ----
package lcdrl_pkg;
   typedef enum logic [2:0] {
      MODE_STATIC = 3'h0,
      MODE_MUX2 = 3'h1,
      MODE_MUX4 = 3'h2,
      MODE_MUX6 = 3'h3,
      MODE_MUX8 = 3'h4
   } lcdrl_mode_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_RECV = 2'h1,
      BUS_ACK = 2'h2
   } lcdrl_bus_e;
   typedef enum logic [1:0] {
      KIND_ADDR = 2'h0,
      KIND_CTRL = 2'h1,
      KIND_DATA = 2'h2
   } lcdrl_kind_e;
   localparam int RAM_COLS = 46;
   localparam logic [5:0] LIM_STD = 6'h2C;
   localparam logic [5:0] LIM_MUX6 = 6'h2E;
   localparam logic [2:0] BANK1_ROW = 3'h4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int CTRL_CONT_BIT = 7;
   localparam int CTRL_TARGET_BIT = 6;
   localparam logic [1:0] SYNC_RST = 2'h3;
   localparam logic [7:0] ACK_ADDR_RW = 8'h00;

   function automatic logic [3:0] lcdrl_rows(input lcdrl_mode_e m);
      case (m)
         MODE_STATIC: return 4'h1;
         MODE_MUX2: return 4'h2;
         MODE_MUX4: return 4'h4;
         MODE_MUX6: return 4'h6;
         default: return 4'h8;
      endcase
   endfunction : lcdrl_rows

   function automatic logic lcdrl_bankable(input lcdrl_mode_e m);
      return (m == MODE_STATIC) || (m == MODE_MUX2) || (m == MODE_MUX4);
   endfunction : lcdrl_bankable
endpackage : lcdrl_pkg

// ---- logic/lcdrl_loader.sv ----
`timescale 1ns/100ps
module lcdrl_loader
   import lcdrl_pkg::*;
#(
   parameter int DEPTH = 2,
   parameter logic [6:0] SLAVE_ADDR = 7'h2A
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   output logic sclOut,
   output logic sclOe,
   input wire logic sda,
   output logic sdaOut,
   output logic sdaOe,
   input wire lcdrl_mode_e driveMode,
   input wire logic inBank,
   input wire logic outBank,
   input wire logic ptrLoad,
   input wire logic [5:0] ptrValue,
   output logic cmdValid,
   input wire logic cmdReady,
   output logic [7:0] cmdData,
   input wire logic [5:0] dispCol,
   output logic [7:0] dispData
);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2)
   begin : g_chk
      $error("DEPTH below two cannot absorb a stall");
   end

   typedef struct packed {
      logic [RAM_COLS-1:0][7:0] ram;
      logic [5:0] ptr;
      logic [2:0] rowOff;
      logic [1:0] sclS;
      logic [1:0] sdaS;
      logic sclP;
      logic sdaP;
      lcdrl_bus_e bus;
      lcdrl_kind_e kind;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic lastCtrl;
      logic target;
      logic pend;
      logic [DEPTH-1:0][8:0] fifo;
      logic [CW-1:0] count;
      logic [7:0] disp;
   } lcdrl_state_s;

   lcdrl_state_s s;
   lcdrl_state_s n;
   logic sclH;
   logic sdaH;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   logic headV;
   logic [8:0] head;
   logic popRam;
   logic popCmd;
   logic fifoReady;
   logic push;
   logic [5:0] lim;

   // ------------------------------------------------------------
   // Line events
   // ------------------------------------------------------------
   assign sclH = s.sclS[1];
   assign sdaH = s.sdaS[1];
   assign sclRise = sclH & ~s.sclP;
   assign sclFall = ~sclH & s.sclP;
   assign startEv = sclH & s.sclP & s.sdaP & ~sdaH;
   assign stopEv = sclH & s.sclP & ~s.sdaP & sdaH;
   assign head = s.fifo[0];
   assign headV = s.count != '0;
   assign popRam = headV & head[8];
   assign popCmd = headV & ~head[8] & cmdReady;
   assign fifoReady = s.count < CW'(DEPTH);
   assign lim = (driveMode == MODE_MUX6) ? LIM_MUX6 : LIM_STD;
   assign cmdValid = headV & ~head[8];
   assign cmdData = head[7:0];
   assign dispData = s.disp;
   assign sdaOut = 1'b0;
   assign sclOut = 1'b0;
   assign sdaOe = s.bus == BUS_ACK;
   assign sclOe = s.pend;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic [5:0] c;
      logic [3:0] r;
      logic [3:0] rpc;
      logic [2:0] base;
      logic [CW-1:0] left;
      c = s.ptr;
      r = {1'b0, s.rowOff};
      rpc = lcdrl_rows(driveMode);
      base = (lcdrl_bankable(driveMode) && inBank) ? BANK1_ROW : 3'h0;
      left = '0;
      push = 1'b0;
      n = s;
      n.sclS = {s.sclS[0], scl};
      n.sdaS = {s.sdaS[0], sda};
      n.sclP = sclH;
      n.sdaP = sdaH;
      case (s.bus)
         BUS_RECV:
         begin
            if (sclRise)
            begin
               n.shift = {s.shift[6:0], sdaH};
               n.cnt = s.cnt + 4'h1;
            end
            else if (sclFall && s.cnt == BYTE_BITS)
            begin
               n.cnt = 4'h0;
               case (s.kind)
                  KIND_ADDR:
                  begin
                     if (s.shift == ({SLAVE_ADDR, 1'b0} | ACK_ADDR_RW))
                     begin
                        n.bus = BUS_ACK;
                        n.kind = KIND_CTRL;
                     end
                     else
                     begin
                        n.bus = BUS_IDLE;
                     end
                  end
                  KIND_CTRL:
                  begin
                     n.lastCtrl = ~s.shift[CTRL_CONT_BIT];
                     n.target = s.shift[CTRL_TARGET_BIT];
                     n.kind = KIND_DATA;
                     n.bus = BUS_ACK;
                  end
                  default:
                  begin
                     n.pend = 1'b1;
                     n.bus = BUS_ACK;
                     n.kind = s.lastCtrl ? KIND_DATA : KIND_CTRL;
                  end
               endcase
            end
         end
         BUS_ACK:
         begin
            if (s.pend && fifoReady)
            begin
               push = 1'b1;
               n.pend = 1'b0;
            end
            else if (!s.pend && sclFall)
            begin
               n.bus = BUS_RECV;
            end
         end
         default:
         begin
            n.bus = BUS_IDLE;
         end
      endcase
      if (startEv)
      begin
         n.bus = BUS_RECV;
         n.kind = KIND_ADDR;
         n.cnt = 4'h0;
         n.pend = 1'b0;
      end
      else if (stopEv)
      begin
         n.bus = BUS_IDLE;
         n.pend = 1'b0;
      end

      // Placement of one RAM byte, MSB first
      if (ptrLoad)
      begin
         n.ptr = ptrValue;
         n.rowOff = 3'h0;
      end
      else if (popRam)
      begin
         for (int k = 7; k >= 0; k--)
         begin
            if (c < lim)
            begin
               n.ram[c][3'(base + r[2:0])] = head[k];
            end
            r = r + 4'h1;
            if (r == rpc)
            begin
               r = 4'h0;
               c = c + 6'h1;
            end
         end
         n.ptr = (c > lim) ? lim : c;
         n.rowOff = r[2:0];
      end

      // DEPTH-entry buffer (two by default), shift out at the head
      if (popRam || popCmd)
      begin
         for (int i = 0; i < DEPTH - 1; i++)
         begin
            n.fifo[i] = s.fifo[i+1];
         end
         left = s.count - CW'(1);
      end
      else
      begin
         left = s.count;
      end
      if (push)
      begin
         n.fifo[left] = {s.target, s.shift};
      end
      n.count = left + CW'(push);

      // Display read with output bank
      if (dispCol < 6'(RAM_COLS))
      begin
         if (lcdrl_bankable(driveMode) && outBank)
         begin
            n.disp = {2{s.ram[dispCol][7:4]}};
         end
         else
         begin
            n.disp = s.ram[dispCol];
         end
      end
      else
      begin
         n.disp = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.sclS <= SYNC_RST;
         s.sdaS <= SYNC_RST;
         s.sclP <= 1'b1;
         s.sdaP <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ptr_load: assert property (ptrLoad |=> s.ptr == $past(ptrValue))
      else $error("pointer load not taken");
   a_step_static: assert property (popRam && !ptrLoad && driveMode == MODE_STATIC
      && s.ptr <= 6'h24 |=> s.ptr == $past(s.ptr) + 6'h8)
      else $error("static step not eight");
   a_step_mux2: assert property (popRam && !ptrLoad && driveMode == MODE_MUX2
      && s.ptr <= 6'h28 |=> s.ptr == $past(s.ptr) + 6'h4)
      else $error("1:2 step not four");
   a_step_mux4: assert property (popRam && !ptrLoad && driveMode == MODE_MUX4
      && s.ptr <= 6'h2A |=> s.ptr == $past(s.ptr) + 6'h2)
      else $error("1:4 step not two");
   a_step_mux8: assert property (popRam && !ptrLoad && driveMode == MODE_MUX8
      && s.ptr <= 6'h2B |=> s.ptr == $past(s.ptr) + 6'h1)
      else $error("1:8 step not one");
   a_step_mux6: assert property (popRam && !ptrLoad && driveMode == MODE_MUX6
      && s.ptr <= 6'h2B |=> (s.ptr - $past(s.ptr)) inside {6'h1, 6'h2})
      else $error("1:6 step not one or two");
   a_ptr_sat: assert property (s.ptr <= LIM_MUX6)
      else $error("pointer past RAM end");
   a_end_drop: assert property (popRam && !ptrLoad && s.ptr >= lim
      |=> $stable(s.ram) && $stable(s.ptr))
      else $error("write past RAM end");
   a_ack_addr: assert property (s.bus == BUS_RECV && sclFall && s.cnt == BYTE_BITS
      && s.kind == KIND_ADDR && s.shift == {SLAVE_ADDR, 1'b0} && !startEv && !stopEv
      |=> sdaOe)
      else $error("address not acknowledged");
   a_ctrl_route: assert property (s.bus == BUS_RECV && sclFall && s.cnt == BYTE_BITS
      && s.kind == KIND_CTRL |=> s.target == $past(s.shift[6]))
      else $error("control route not latched");
   a_cmd_hold: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdData))
      else $error("command dropped while stalled");
   a_stop_idle: assert property (stopEv && !startEv |=> s.bus == BUS_IDLE)
      else $error("stop not honoured");

   c_ram_write: cover property (popRam && s.ptr < lim);
   c_cmd_stall: cover property ((cmdValid && !cmdReady) [*3]);
   c_buf_full: cover property (s.pend && !fifoReady);
   c_mux6_two: cover property (popRam && driveMode == MODE_MUX6 ##1 s.rowOff == 3'h2);
endmodule : lcdrl_loader

// ---- dv/lcdrl_i2c_master.sv ----
`timescale 1ns/100ps
module lcdrl_i2c_master (
   output logic sclDrv,
   output logic sdaDrv,
   input wire logic scl,
   input wire logic sda
);
   // ----------------------------------------
   // Open-drain host, 80 ns bit period
   // ----------------------------------------
   initial
   begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
   end

   // Release clock, honour stretching
   task automatic sclHigh();
      int n;
      n = 0;
      sclDrv = 1'b1;
      while (scl !== 1'b1 && n < 20000)
      begin
         #10;
         n++;
      end
      #40;
   endtask : sclHigh

   task automatic start();
      sdaDrv = 1'b1;
      sclHigh();
      sdaDrv = 1'b0;
      #40;
      sclDrv = 1'b0;
      #40;
   endtask : start

   task automatic stop();
      sdaDrv = 1'b0;
      #40;
      sclHigh();
      sdaDrv = 1'b1;
      #40;
   endtask : stop

   // Data changes only while clock is low
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sdaDrv = b[i];
         #40;
         sclHigh();
         sclDrv = 1'b0;
      end
      sdaDrv = 1'b1;
      #40;
      sclHigh();
      ack = sda;
      sclDrv = 1'b0;
   endtask : sendByte
endmodule : lcdrl_i2c_master

// ---- dv/lcdrl_loader_bench.sv ----
`timescale 1ns/100ps
module lcdrl_loader_bench;
   import lcdrl_pkg::*;
   localparam logic [6:0] DEV_ADDR = 7'h2A;
   logic clk = 1'b0, rst = 1'b1, inBank = 1'b0, outBank = 1'b0, ptrLoad = 1'b0, cmdReady = 1'b0;
   logic sclDrv, sdaDrv, sclOe, sdaOe, cmdValid, ack, sclOut, sdaOut;
   logic [5:0] ptrValue = 6'h00, dispCol = 6'h00;
   logic [7:0] cmdData, dispData, b;
   logic [7:0] ram [46];
   logic [7:0] cmdQ [$];
   lcdrl_mode_e driveMode = MODE_STATIC;
   int mismatches = 0, total_checks = 0, cycles = 0, col, roff, lim, rows, base;
   wire logic scl = sclDrv & (~sclOe | sclOut);
   wire logic sda = sdaDrv & (~sdaOe | sdaOut);

   lcdrl_i2c_master host (.sclDrv(sclDrv), .sdaDrv(sdaDrv), .scl(scl), .sda(sda));
   lcdrl_loader #(.SLAVE_ADDR(DEV_ADDR)) uut (.clk(clk), .rst(rst), .scl(scl), .sclOut(sclOut),
      .sclOe(sclOe), .sda(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .driveMode(driveMode),
      .inBank(inBank), .outBank(outBank), .ptrLoad(ptrLoad), .ptrValue(ptrValue),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdData(cmdData), .dispCol(dispCol),
      .dispData(dispData));

   always #5 clk = ~clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // Bit-serial placement, column by column, saturating
   task automatic place(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
      begin
         if (col < lim)
         begin
            ram[col][base + roff] = d[i];
            roff++;
         end
         if (roff == rows)
         begin
            roff = 0;
            col++;
         end
      end
   endtask : place

   always @(negedge clk) cmdReady <= 1'($urandom_range(0, 1));

   always @(posedge clk)
   begin
      cycles++;
      if (!rst && cmdValid === 1'b1 && cmdReady)
         chk(cmdData, cmdQ.pop_front());
      if (cycles == 40000)
      begin
         mismatches++;
         summarize();
      end
   end

   initial
   begin
      void'($urandom(64));
      foreach (ram[c]) ram[c] = 8'h00;
      repeat (3) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      // ----------------------------------------
      // Fill past the end in every drive mode
      // ----------------------------------------
      for (int m = 0; m < 5; m++)
      begin
         @(negedge clk);
         driveMode = lcdrl_mode_e'(m);
         inBank = (m != 1);
         col = $urandom_range(0, 7);
         ptrValue = col[5:0];
         ptrLoad = 1'b1;
         @(negedge clk) ptrLoad = 1'b0;
         rows = (m == 3) ? 6 : (m == 4) ? 8 : (1 << m);
         lim = (m == 3) ? 46 : 44;
         base = (inBank && m < 3) ? 4 : 0;
         roff = 0;
         host.start();
         host.sendByte({DEV_ADDR, 1'b0}, ack);
         chk({7'h00, ack}, 8'h00);
         host.sendByte(8'h80 | 8'($urandom_range(0, 63)), ack);
         b = 8'($urandom);
         cmdQ.push_back(b);
         host.sendByte(b, ack);
         host.sendByte(8'h40 | 8'($urandom_range(0, 63)), ack);
         for (int k = 0; k < 46; k++)
         begin
            b = 8'($urandom);
            place(b);
            host.sendByte(b, ack);
            chk({7'h00, ack}, 8'h00);
         end
         host.stop();
         for (int c = 0; c < 46; c++)
         begin
            @(negedge clk);
            dispCol = 6'(c);
            outBank = 1'b0;
            @(negedge clk) chk(dispData, ram[c]);
            outBank = 1'b1;
            @(negedge clk);
            @(negedge clk) chk(dispData, (m < 3) ? {2{ram[c][7:4]}} : ram[c]);
         end
      end
      // ----------------------------------------
      // Wrong address and read request refused
      // ----------------------------------------
      for (int k = 0; k < 2; k++)
      begin
         host.start();
         host.sendByte(k ? {DEV_ADDR, 1'b1} : {DEV_ADDR ^ 7'h01, 1'b0}, ack);
         chk({7'h00, ack}, 8'h01);
         host.stop();
      end
      chk(8'(cmdQ.size()), 8'h00);
      summarize();
   end
endmodule : lcdrl_loader_bench
